/* File: rtl/slt_pkg.sv */
package slt_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [9:0] IDX_TEST = 10'h205;
  localparam logic [9:0] IDX_IDENT = 10'h206;
  localparam logic [9:0] IDX_EOF = 10'h207;
  localparam logic [9:0] IDX_STATUS = 10'h208;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 11;

  // Field widths and reset values
  localparam int TEST_SEL_W = 5;
  localparam int EOF_SEL_W = 2;
  localparam int IDENT_HI_W = 7;
  localparam logic [4:0] TEST_SEL_RST = 5'h00;
  localparam logic [6:0] IDENT_HI_RST = 7'h00;
  localparam logic [1:0] EOF_SEL_RST = 2'h0;

  // Status bit positions
  localparam int ST_LINK_UP = 6;
  localparam int ST_SYNC = 5;
  localparam int ST_REALIGNED = 4;
  localparam int ST_ALIGNED = 3;
  localparam int ST_PLL = 2;

  // Test pattern selector codes
  localparam logic [4:0] TP_NORMAL = 5'h00;
  localparam logic [4:0] TP_PRBS7 = 5'h01;
  localparam logic [4:0] TP_PRBS15 = 5'h02;
  localparam logic [4:0] TP_PRBS23 = 5'h03;
  localparam logic [4:0] TP_RAMP = 5'h04;
  localparam logic [4:0] TP_TRANSPORT = 5'h05;
  localparam logic [4:0] TP_D21_5 = 5'h06;
  localparam logic [4:0] TP_K28_5 = 5'h07;
  localparam logic [4:0] TP_ILA = 5'h08;
  localparam logic [4:0] TP_RPAT = 5'h09;
  localparam logic [4:0] TP_LOW = 5'h0a;
  localparam logic [4:0] TP_HIGH = 5'h0b;
  localparam logic [4:0] TP_PRBS9 = 5'h0d;
  localparam logic [4:0] TP_PRBS31 = 5'h0e;
  localparam logic [4:0] TP_CLOCK = 5'h0f;
  localparam logic [4:0] TP_K28_7 = 5'h10;

  // End-of-frame selector codes
  localparam logic [1:0] EOF_K28_7 = 2'h0;
  localparam logic [1:0] EOF_K28_1 = 2'h1;
  localparam logic [1:0] EOF_K28_5 = 2'h2;

  // Character values
  localparam logic [7:0] CH_K28_0 = 8'h1c;
  localparam logic [7:0] CH_K28_1 = 8'h3c;
  localparam logic [7:0] CH_K28_3 = 8'h7c;
  localparam logic [7:0] CH_K28_4 = 8'h9c;
  localparam logic [7:0] CH_K28_5 = 8'hbc;
  localparam logic [7:0] CH_K28_7 = 8'hfc;
  localparam logic [7:0] CH_D21_5 = 8'hb5;

  // Fixed lane words
  localparam int LANE_W = 16;
  localparam int WORD_W = 18;
  localparam logic [15:0] WORD_LOW = 16'h0000;
  localparam logic [15:0] WORD_HIGH = 16'hffff;
  localparam logic [15:0] WORD_CLOCK = 16'h00ff;
  localparam logic [1:0] K_NONE = 2'h0;
  localparam logic [1:0] K_BOTH = 2'h3;
  localparam logic [1:0] K_LOW = 2'h1;
  localparam logic [1:0] K_HIGH = 2'h2;

  // Alignment sequence: four multiframes of eight words
  localparam logic [1:0] ILA_DID_MF = 2'h1;
  localparam logic [2:0] ILA_DID_POS = 3'h1;
  localparam logic [2:0] ILA_FIRST_POS = 3'h0;
  localparam logic [2:0] ILA_LAST_POS = 3'h7;

  // PRBS length-1 and tap-1 pairs
  localparam logic [9:0] PRBS7_LT = {5'h06, 5'h05};
  localparam logic [9:0] PRBS9_LT = {5'h08, 5'h04};
  localparam logic [9:0] PRBS15_LT = {5'h0e, 5'h0d};
  localparam logic [9:0] PRBS23_LT = {5'h16, 5'h11};
  localparam logic [9:0] PRBS31_LT = {5'h1e, 5'h1b};
  localparam logic [30:0] PRBS_SEED = 31'h7fffffff;

  localparam logic [31:0] RD_ZERO = 32'h00000000;

  typedef enum {
    PK_NORMAL, PK_PRBS, PK_RAMP, PK_TRANSPORT, PK_ILA, PK_RPAT, PK_FIXED
  } slt_pat_t;

  // Modified random pattern, eight words repeated
  function automatic logic [15:0] rpat_word(input logic [2:0] idx);
    logic [15:0] w;
    w = 16'h0000;
    unique case (idx)
      3'h0: w = 16'hd7be;
      3'h1: w = 16'h4723;
      3'h2: w = 16'h8f6b;
      3'h3: w = 16'h14b3;
      3'h4: w = 16'hfb5e;
      3'h5: w = 16'h5935;
      3'h6: w = 16'hbe7e;
      3'h7: w = 16'h2a6b;
    endcase
    return w;
  endfunction

endpackage

/* File: rtl/slt_stream_if.sv */
`timescale 1ns/1ps
interface slt_stream_if;
  logic [17:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

/* File: rtl/slt_skid_buf.sv */
`timescale 1ns/1ps
module slt_skid_buf (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Streams
  slt_stream_if.snk wr,
  slt_stream_if.src rd
);
  // Entry 0 feeds the output, entry 1 catches a word during a stall
  logic [slt_pkg::WORD_W-1:0] mem [2];
  logic [slt_pkg::WORD_W-1:0] next_mem [2];
  logic [1:0] full;
  logic [1:0] next_full;
  logic rdy;
  logic next_rdy;

  always_comb begin
    next_mem[0] = mem[0];
    next_mem[1] = mem[1];
    next_full = full;
    if (rd.ready || !full[0]) begin
      if (full[1]) begin
        next_mem[0] = mem[1];
        next_full = 2'h1;
      end else begin
        next_mem[0] = wr.data;
        next_full[0] = wr.valid && rdy;
      end
    end else if (wr.valid && rdy) begin
      // Stalled receiver: park the word instead of losing it
      next_mem[1] = wr.data;
      next_full[1] = 1'b1;
    end
    next_rdy = !next_full[1];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem[0] <= '0;
      mem[1] <= '0;
      full <= 2'h0;
      rdy <= 1'b1;
    end else begin
      mem <= next_mem;
      full <= next_full;
      rdy <= next_rdy;
    end
  end

  assign wr.ready = rdy;
  assign rd.data = mem[0];
  assign rd.valid = full[0];
endmodule // slt_skid_buf

/* File: rtl/slt_link_test_top.sv */
`timescale 1ns/1ps
// What this block does
// - Five-bit test selector, zero means normal
// - PRBS7/15/23/9/31 on their codes
// - Code 4 ramp, code 5 transport pattern
// - Repeated D21.5, K28.5, K28.7 characters
// - Code 8 repeated alignment, 9 modified RPAT
// - Codes 10/11 hold lanes low/high
// - Code 15 sends 0x00FF clock word
// - Codes 7,8,9,16 only in 8b/10b
// - Eight-bit identifier sent in second multiframe
// - Link A sends identifier, link B plus one
// - Identifier bit zero ignored, reads zero
// - Two-bit end-of-frame character selector
// - End-of-frame character only in 8b/10b
module slt_link_test_top (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link control and status from the rest of the transmitter
  input wire logic serial_link_enable,
  input wire logic link_mode_is_8b10b,
  input wire logic link_up,
  input wire logic sync_deasserted,
  input wire logic pll_locked,
  input wire logic phase_aligned_evt,
  input wire logic phase_realigned_evt,
  // Sample stream in
  input wire logic [15:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  // Lane stream out
  output logic [15:0] lane_data,
  output logic [1:0] lane_is_k,
  output logic lane_valid,
  input wire logic lane_ready,
  // Identifiers, end-of-frame control and pattern flag for the link layer
  output logic [7:0] link_a_ident,
  output logic [7:0] link_b_ident,
  output logic [7:0] eof_char,
  output logic eof_insert_en,
  output logic pattern_active
);

  slt_stream_if buf_in ();
  slt_stream_if buf_out ();

  // Pattern kind from selector; 8b/10b-only codes fall back to data
  function automatic slt_pkg::slt_pat_t pat_kind(input logic [4:0] sel,
      input logic is_8b10b);
    slt_pkg::slt_pat_t k;
    k = slt_pkg::PK_NORMAL;
    unique case (sel)
      slt_pkg::TP_PRBS7, slt_pkg::TP_PRBS15, slt_pkg::TP_PRBS23,
      slt_pkg::TP_PRBS9, slt_pkg::TP_PRBS31: k = slt_pkg::PK_PRBS;
      slt_pkg::TP_RAMP: k = slt_pkg::PK_RAMP;
      slt_pkg::TP_TRANSPORT: k = slt_pkg::PK_TRANSPORT;
      slt_pkg::TP_D21_5, slt_pkg::TP_LOW, slt_pkg::TP_HIGH,
      slt_pkg::TP_CLOCK: k = slt_pkg::PK_FIXED;
      slt_pkg::TP_K28_5, slt_pkg::TP_K28_7:
        k = is_8b10b ? slt_pkg::PK_FIXED : slt_pkg::PK_NORMAL;
      slt_pkg::TP_ILA:
        k = is_8b10b ? slt_pkg::PK_ILA : slt_pkg::PK_NORMAL;
      slt_pkg::TP_RPAT:
        k = is_8b10b ? slt_pkg::PK_RPAT : slt_pkg::PK_NORMAL;
      default: k = slt_pkg::PK_NORMAL;
    endcase
    return k;
  endfunction

  // Sixteen serial steps of a Fibonacci LFSR; returns state and word
  function automatic logic [46:0] prbs16(input logic [30:0] s_in,
      input logic [9:0] lt);
    logic [30:0] s;
    logic [15:0] w;
    logic fb;
    s = s_in;
    w = 16'h0000;
    fb = 1'b0;
    for (int i = 0; i < slt_pkg::LANE_W; i++) begin
      fb = s[lt[9:5]] ^ s[lt[4:0]];
      w[i] = fb;
      s = {s[29:0], fb};
    end
    return {s, w};
  endfunction

  // Register group
  logic [4:0] test_sel;
  logic [6:0] ident_hi;
  logic [1:0] eof_sel;
  logic aligned;
  logic realigned;
  logic [4:0] next_test_sel;
  logic [6:0] next_ident_hi;
  logic [1:0] next_eof_sel;
  logic next_aligned;
  logic next_realigned;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [7:0] next_link_a_ident;
  logic [7:0] next_link_b_ident;
  logic [7:0] next_eof_char;
  logic next_eof_insert_en;
  logic next_pattern_active;
  logic [9:0] word_idx;
  logic setup;
  logic wr_take;
  logic [7:0] status_rd;

  assign word_idx = paddr[slt_pkg::ADDR_MSB:slt_pkg::ADDR_LSB];
  assign setup = psel && !penable;
  assign wr_take = psel && penable && pready && pwrite;

  always_comb begin
    next_test_sel = test_sel;
    next_ident_hi = ident_hi;
    next_eof_sel = eof_sel;
    // Event set wins over a write-one clear in the same cycle
    next_aligned = aligned || phase_aligned_evt;
    next_realigned = realigned || phase_realigned_evt;
    if (wr_take) begin
      unique case (word_idx)
        slt_pkg::IDX_TEST:
          next_test_sel = pwdata[slt_pkg::TEST_SEL_W-1:0];
        slt_pkg::IDX_IDENT:
          next_ident_hi = pwdata[slt_pkg::IDENT_HI_W:1];
        slt_pkg::IDX_EOF:
          next_eof_sel = pwdata[slt_pkg::EOF_SEL_W-1:0];
        slt_pkg::IDX_STATUS: begin
          next_aligned = (aligned && !pwdata[slt_pkg::ST_ALIGNED])
              || phase_aligned_evt;
          next_realigned = (realigned && !pwdata[slt_pkg::ST_REALIGNED])
              || phase_realigned_evt;
        end
        default: ;
      endcase
    end
    status_rd = 8'h00;
    status_rd[slt_pkg::ST_LINK_UP] = link_up;
    status_rd[slt_pkg::ST_SYNC] = sync_deasserted;
    status_rd[slt_pkg::ST_REALIGNED] = realigned;
    status_rd[slt_pkg::ST_ALIGNED] = aligned;
    status_rd[slt_pkg::ST_PLL] = pll_locked;
    // Answer is prepared in the setup cycle, so access lasts one cycle
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = slt_pkg::RD_ZERO;
    if (setup) begin
      unique case (word_idx)
        slt_pkg::IDX_TEST: next_prdata = {27'h0, test_sel};
        slt_pkg::IDX_IDENT: next_prdata = {24'h0, ident_hi, 1'b0};
        slt_pkg::IDX_EOF: next_prdata = {30'h0, eof_sel};
        slt_pkg::IDX_STATUS: next_prdata = {24'h0, status_rd};
        default: next_pslverr = 1'b1;
      endcase
    end
    next_link_a_ident = {next_ident_hi, 1'b0};
    next_link_b_ident = {next_ident_hi, 1'b1};
    unique case (next_eof_sel)
      slt_pkg::EOF_K28_1: next_eof_char = slt_pkg::CH_K28_1;
      slt_pkg::EOF_K28_5: next_eof_char = slt_pkg::CH_K28_5;
      default: next_eof_char = slt_pkg::CH_K28_7;
    endcase
    next_eof_insert_en = link_mode_is_8b10b && serial_link_enable;
    next_pattern_active = serial_link_enable
        && pat_kind(next_test_sel, link_mode_is_8b10b)
        != slt_pkg::PK_NORMAL;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      test_sel <= slt_pkg::TEST_SEL_RST;
      ident_hi <= slt_pkg::IDENT_HI_RST;
      eof_sel <= slt_pkg::EOF_SEL_RST;
      aligned <= 1'b0;
      realigned <= 1'b0;
      prdata <= slt_pkg::RD_ZERO;
      pready <= 1'b0;
      pslverr <= 1'b0;
      link_a_ident <= 8'h00;
      link_b_ident <= 8'h01;
      eof_char <= slt_pkg::CH_K28_7;
      eof_insert_en <= 1'b0;
      pattern_active <= 1'b0;
    end else begin
      test_sel <= next_test_sel;
      ident_hi <= next_ident_hi;
      eof_sel <= next_eof_sel;
      aligned <= next_aligned;
      realigned <= next_realigned;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      link_a_ident <= next_link_a_ident;
      link_b_ident <= next_link_b_ident;
      eof_char <= next_eof_char;
      eof_insert_en <= next_eof_insert_en;
      pattern_active <= next_pattern_active;
    end
  end

  // Pattern generator group
  slt_pkg::slt_pat_t kind;
  logic [30:0] lfsr;
  logic [7:0] step;
  logic [4:0] last_sel;
  logic [30:0] next_lfsr;
  logic [7:0] next_step;
  logic [4:0] next_last_sel;
  logic [46:0] pr;
  logic [9:0] lt;
  logic [15:0] gen_word;
  logic [1:0] gen_k;
  logic push;
  logic adv;
  logic [7:0] ramp;

  assign kind = pat_kind(test_sel, link_mode_is_8b10b);
  assign ramp = {step[6:0], 1'b0};

  always_comb begin
    unique case (test_sel)
      slt_pkg::TP_PRBS9: lt = slt_pkg::PRBS9_LT;
      slt_pkg::TP_PRBS15: lt = slt_pkg::PRBS15_LT;
      slt_pkg::TP_PRBS23: lt = slt_pkg::PRBS23_LT;
      slt_pkg::TP_PRBS31: lt = slt_pkg::PRBS31_LT;
      default: lt = slt_pkg::PRBS7_LT;
    endcase
    pr = prbs16(lfsr, lt);
    gen_word = sample_data;
    gen_k = slt_pkg::K_NONE;
    unique case (kind)
      slt_pkg::PK_NORMAL: gen_word = sample_data;
      slt_pkg::PK_PRBS: gen_word = pr[15:0];
      slt_pkg::PK_RAMP: gen_word = {ramp + 8'h01, ramp};
      slt_pkg::PK_TRANSPORT: gen_word = {~ramp, ramp};
      slt_pkg::PK_RPAT: gen_word = slt_pkg::rpat_word(step[2:0]);
      slt_pkg::PK_ILA: begin
        // Each multiframe opens with K28.0 and closes with K28.3
        gen_word = {ramp, ramp};
        if (step[2:0] == slt_pkg::ILA_FIRST_POS) begin
          gen_word = {ramp, slt_pkg::CH_K28_0};
          gen_k = slt_pkg::K_LOW;
        end else if (step[2:0] == slt_pkg::ILA_LAST_POS) begin
          gen_word = {slt_pkg::CH_K28_3, ramp};
          gen_k = slt_pkg::K_HIGH;
        end else if (step[4:3] == slt_pkg::ILA_DID_MF
            && step[2:0] == slt_pkg::ILA_DID_POS) begin
          gen_word = {link_a_ident, slt_pkg::CH_K28_4};
          gen_k = slt_pkg::K_LOW;
        end
      end
      slt_pkg::PK_FIXED: begin
        unique case (test_sel)
          slt_pkg::TP_D21_5:
            gen_word = {slt_pkg::CH_D21_5, slt_pkg::CH_D21_5};
          slt_pkg::TP_K28_5: begin
            gen_word = {slt_pkg::CH_K28_5, slt_pkg::CH_K28_5};
            gen_k = slt_pkg::K_BOTH;
          end
          slt_pkg::TP_K28_7: begin
            gen_word = {slt_pkg::CH_K28_7, slt_pkg::CH_K28_7};
            gen_k = slt_pkg::K_BOTH;
          end
          slt_pkg::TP_LOW: gen_word = slt_pkg::WORD_LOW;
          slt_pkg::TP_HIGH: gen_word = slt_pkg::WORD_HIGH;
          default: gen_word = slt_pkg::WORD_CLOCK;
        endcase
      end
    endcase
    // Samples are drained and dropped while a pattern runs
    push = serial_link_enable
        && (kind != slt_pkg::PK_NORMAL || sample_valid);
    adv = push && buf_in.ready;
    next_last_sel = test_sel;
    next_lfsr = lfsr;
    next_step = step;
    // A new selection or a disabled link restarts every sequence
    if (!serial_link_enable || test_sel != last_sel) begin
      next_lfsr = slt_pkg::PRBS_SEED;
      next_step = 8'h00;
    end else if (adv) begin
      next_lfsr = pr[46:16];
      next_step = step + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr <= slt_pkg::PRBS_SEED;
      step <= 8'h00;
      last_sel <= slt_pkg::TEST_SEL_RST;
    end else begin
      lfsr <= next_lfsr;
      step <= next_step;
      last_sel <= next_last_sel;
    end
  end

  assign buf_in.valid = push;
  assign buf_in.data = {gen_k, gen_word};
  assign buf_out.ready = lane_ready;

  slt_skid_buf u_buf (
    .clk(clk),
    .nrst(nrst),
    .wr(buf_in),
    .rd(buf_out)
  );

  assign sample_ready = buf_in.ready;
  assign lane_data = buf_out.data[15:0];
  assign lane_is_k = buf_out.data[17:16];
  assign lane_valid = buf_out.valid;

endmodule // slt_link_test_top

/* File: bench/slt_link_test_checker.sv */
`timescale 1ns/1ps
module slt_link_test_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus and link control
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_link_enable,
  input wire logic link_mode_is_8b10b,
  // Lane stream and link parameters
  input wire logic [15:0] lane_data,
  input wire logic [1:0] lane_is_k,
  input wire logic lane_valid,
  input wire logic lane_ready,
  input wire logic [7:0] link_a_ident,
  input wire logic [7:0] link_b_ident,
  input wire logic [7:0] eof_char,
  input wire logic eof_insert_en,
  input wire logic pattern_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer in the access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  ident_pair_a: assert property (link_b_ident == link_a_ident + 8'h01
    && !link_a_ident[0])
    else $error("link identifiers not an even pair");
  eof_code_a: assert property (eof_char inside {8'hfc, 8'h3c, 8'hbc})
    else $error("end of frame character not a listed comma");
  eof_mode_a: assert property ($past(nrst) |-> eof_insert_en ==
    ($past(serial_link_enable) && $past(link_mode_is_8b10b)))
    else $error("end of frame insertion outside 8b10b");
  idle_plain_a: assert property ($past(nrst) && !$past(serial_link_enable)
    |-> !pattern_active)
    else $error("pattern flagged while disabled");
  lane_hold_a: assert property (lane_valid && !lane_ready |=> lane_valid
    && $stable(lane_data) && $stable(lane_is_k))
    else $error("lane word changed while stalled");

  // Main scenarios
  cover property (lane_valid && !lane_ready);
  cover property (pslverr);
  cover property (pattern_active && lane_valid && lane_ready);
endmodule // slt_link_test_checker

/* File: bench/slt_lane_rx.sv */
`timescale 1ns/1ps
module slt_lane_rx (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Lane stream
  input wire logic [15:0] lane_data,
  input wire logic [1:0] lane_is_k,
  input wire logic lane_valid,
  output logic lane_ready,
  // Stall request
  input wire logic stall
);
  // Words kept with their K flags on top
  logic [17:0] got [$];

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lane_ready <= 1'b0;
    end else begin
      if (lane_valid && lane_ready) begin
        got.push_back({lane_is_k, lane_data});
      end
      lane_ready <= !stall;
    end
  end
endmodule // slt_lane_rx

/* File: bench/slt_link_test_bench.sv */
`timescale 1ns/1ps
module slt_link_test_bench;
  typedef struct {logic [4:0] code; logic m8; logic [17:0] exp;} slt_row_t;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic en, m8, s_valid, s_ready, l_valid, l_ready, stall;
  logic [15:0] l_data;
  logic [1:0] l_k;
  logic [4:0] st;
  logic [7:0] id_a, id_b, eofc;
  logic eof_en, pat;
  int n_errors = 0;
  int total_checks = 0;
  int hits;
  // Plain sample word, unlike any fixed pattern
  slt_row_t rows [11] = '{'{5'h00, 1'b1, 18'h01234}, '{5'h06, 1'b1, 18'h0b5b5},
    '{5'h07, 1'b1, 18'h3bcbc}, '{5'h10, 1'b1, 18'h3fcfc},
    '{5'h0a, 1'b1, 18'h00000}, '{5'h0b, 1'b0, 18'h0ffff},
    '{5'h0f, 1'b1, 18'h000ff}, '{5'h07, 1'b0, 18'h01234},
    '{5'h09, 1'b0, 18'h01234}, '{5'h0c, 1'b1, 18'h01234},
    '{5'h1f, 1'b1, 18'h01234}};
  logic [4:0] pc [7] = '{5'h01, 5'h02, 5'h03, 5'h0d, 5'h0e, 5'h05, 5'h09};
  logic [7:0] eofx [4] = '{8'hfc, 8'h3c, 8'hbc, 8'hfc};

  slt_link_test_top DUT (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_link_enable(en), .link_mode_is_8b10b(m8), .link_up(st[0]),
    .sync_deasserted(st[1]), .pll_locked(st[2]), .phase_aligned_evt(st[3]),
    .phase_realigned_evt(st[4]), .sample_data(16'h1234),
    .sample_valid(s_valid), .sample_ready(s_ready), .lane_data(l_data),
    .lane_is_k(l_k), .lane_valid(l_valid), .lane_ready(l_ready),
    .link_a_ident(id_a), .link_b_ident(id_b), .eof_char(eofc),
    .eof_insert_en(eof_en), .pattern_active(pat));
  slt_lane_rx rx (.clk(clk), .nrst(nrst), .lane_data(l_data),
    .lane_is_k(l_k), .lane_valid(l_valid), .lane_ready(l_ready),
    .stall(stall));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] g, input logic [31:0] e,
                       input string what);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask

  task automatic fail_wait(input string what);
    n_errors++;
    $display("mismatch at %0t: timeout on %s", $time, what);
    finish_test();
  endtask

  // Request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // Ready, data and error are all taken at the edge that sees ready
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) fail_wait("bus");
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_words(input int n);
    int c;
    c = 0;
    while (rx.got.size() < n) begin
      c++;
      if (c > 300) fail_wait("lane");
      @(posedge clk);
    end
  endtask

  // Settings change only with the link disabled
  task automatic run_code(input logic [4:0] c, input logic m);
    en <= 1'b0;
    @(posedge clk);
    apb(1'b1, 12'h814, {27'h0, c}, rd, err);
    m8 <= m;
    en <= 1'b1;
    rx.got.delete();
    wait_words(6);
  endtask

  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    en = 1'b0;
    m8 = 1'b1;
    s_valid = 1'b1;
    stall = 1'b0;
    st = 5'h05;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      run_code(rows[i].code, rows[i].m8);
      check({14'h0, rx.got[3]}, {14'h0, rows[i].exp}, "lane word");
    end
    check({31'h0, eof_en}, 32'h1, "eof on");
    m8 <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, eof_en}, 32'h0, "eof off");
    $display("fixed codes done");
    foreach (pc[i]) begin
      run_code(pc[i], 1'b1);
      check({31'h0, pat}, 32'h1, "pattern flag");
      check({31'h0, rx.got[3][15:0] == 16'h1234}, 32'h0, "pattern");
      check({31'h0, rx.got[3] == rx.got[4]}, 32'h0, "pattern moves");
    end
    $display("generated codes done");
    // Stall mid ramp: a lost word breaks the step
    run_code(5'h04, 1'b1);
    stall <= 1'b1;
    repeat (5) @(posedge clk);
    stall <= 1'b0;
    wait_words(16);
    for (int i = 2; i < 15; i++) begin
      check({24'h0, rx.got[i+1][7:0]}, {24'h0, rx.got[i][7:0] + 8'h2}, "ramp");
      check({24'h0, rx.got[i][15:8]}, {24'h0, rx.got[i][7:0] + 8'h1}, "ramp");
    end
    run_code(5'h00, 1'b1);
    stall <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    check({31'h0, s_ready}, 32'h0, "buffer full");
    @(posedge clk);
    stall <= 1'b0;
    $display("stall done");
    nrst <= 1'b0;
    en <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h814, 32'h0, rd, err);
    check(rd, 32'h0, "sel reset");
    apb(1'b0, 12'h818, 32'h0, rd, err);
    check(rd, 32'h0, "ident reset");
    apb(1'b0, 12'h81c, 32'h0, rd, err);
    check(rd, 32'h0, "eof reset");
    check({24'h0, id_b}, 32'h01, "ident b reset");
    apb(1'b1, 12'h814, 32'hffffffff, rd, err);
    apb(1'b0, 12'h814, 32'h0, rd, err);
    check(rd, 32'h1f, "sel width");
    apb(1'b1, 12'h818, 32'h000000ab, rd, err);
    apb(1'b0, 12'h818, 32'h0, rd, err);
    check(rd, 32'haa, "ident even");
    check({24'h0, id_a}, 32'haa, "ident a");
    check({24'h0, id_b}, 32'hab, "ident b");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 12'h81c, 32'(c), rd, err);
      apb(1'b0, 12'h81c, 32'h0, rd, err);
      check(rd, 32'(c), "eof sel");
      check({24'h0, eofc}, {24'h0, eofx[c]}, "eof char");
    end
    // Back to the compliant comma before the link runs again
    apb(1'b1, 12'h81c, 32'h0, rd, err);
    check({24'h0, eofc}, 32'hfc, "eof compliant");
    apb(1'b0, 12'h000, 32'h0, rd, err);
    check({31'h0, err}, 32'h1, "unmapped");
    $display("registers done");
    run_code(5'h08, 1'b1);
    wait_words(40);
    hits = 0;
    foreach (rx.got[i]) begin
      if (rx.got[i] === {2'h1, 8'haa, 8'h9c}) hits++;
    end
    check({31'h0, hits > 0}, 32'h1, "ident in alignment");
    $display("alignment done");
    finish_test();
  end
endmodule // slt_link_test_bench

bind slt_link_test_top slt_link_test_checker chk (.clk(clk), .nrst(nrst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .serial_link_enable(serial_link_enable),
  .link_mode_is_8b10b(link_mode_is_8b10b), .lane_data(lane_data),
  .lane_is_k(lane_is_k), .lane_valid(lane_valid), .lane_ready(lane_ready),
  .link_a_ident(link_a_ident), .link_b_ident(link_b_ident),
  .eof_char(eof_char), .eof_insert_en(eof_insert_en),
  .pattern_active(pattern_active));
